//--- sync_serial_shift_port.sv
// sync_serial_shift_port: 8-bit serial shift port, master or slave.
// assumes a cpu-side model drives the control bits as plain ports and
// pops received bytes from the receive FIFO.
// Functional notes
// - eight-bit shift register moves data in on serial in, out on serial out
// - internal shift clock makes a master; external shift clock makes a slave
// - port is active and pins routed only while port select is one
// - master period 2, 4 or 8 cycles from rate select high/low
// - setting busy starts shifting; hardware clears busy after eight bits
// - software clearing busy early stops shifting with fewer bits moved
// - with interrupt enabled, a completed eight-bit shift requests interrupt
// - only the master drives the shift clock and starts transfers
// - master: bit5 output carries shift clock; bit4 output or high impedance
// - slave: bit5 input takes shift clock; bit4 output or high impedance
// - shift clock output rests low when no shift is in progress
// - slave clears busy after eight external shift clock pulses
// - normal phase: sample on rising, shift and output on falling edge
// - alternate phase: sample on falling, present output on rising edge
// - phase select sits on port g bit6 config; set means alternate
// - phase select comes up cleared at reset, normal phase
`default_nettype none
module sync_serial_shift_port
  import shift_port_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // control bits
  input wire logic serial_port_select_in,
  input wire logic rate_select_low_in,
  input wire logic rate_select_high_in,
  input wire logic int_enable_in,
  input wire logic [2:0] port_g_config_in, // bit4, bit5, bit6 config
  // busy flag of the processor status word
  input wire logic busy_set_in,
  input wire logic busy_clear_in,
  output logic busy_out,
  // software load of the shift register
  input wire logic load_in,
  input wire logic [shift_port_pkg::DATA_W-1:0] load_data_in,
  output logic [shift_port_pkg::DATA_W-1:0] shift_data_out,
  // received bytes
  output logic rx_valid_out,
  output logic [shift_port_pkg::DATA_W-1:0] rx_data_out,
  input wire logic rx_ready_in,
  output logic done_irq_out,
  // link pins; output enables are low while driving
  input wire logic serial_in,
  input wire logic shift_clock_in,
  output logic shift_clock_out,
  output logic shift_clock_oe_n_out,
  output logic serial_out,
  output logic serial_oe_n_out
);
  import shift_port_pkg::*;

  logic ck_lvl, ck_rise, ck_fall, si_lvl;
  logic fifo_full_n;
  byte_stream_if rx_if ();

  link_sampler u_sampler (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clk_pin_in(shift_clock_in),
    .data_pin_in(serial_in),
    .clk_level_out(ck_lvl),
    .clk_rise_out(ck_rise),
    .clk_fall_out(ck_fall),
    .data_level_out(si_lvl)
  );

  byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(rx_if.valid),
    .in_data_in(rx_if.data),
    .in_ready_out(fifo_full_n),
    .out_valid_out(rx_valid_out),
    .out_data_out(rx_data_out),
    .out_ready_in(rx_ready_in)
  );
  assign rx_if.ready = fifo_full_n;

  // half period of the master shift clock from the rate bits
  function automatic logic [3:0] half_period(input logic hi, input logic lo);
    if (hi) begin
      half_period = RATE_PERIOD_1X >> 1;
    end else if (lo) begin
      half_period = RATE_PERIOD_01 >> 1;
    end else begin
      half_period = RATE_PERIOD_00 >> 1;
    end
  endfunction : half_period

  shift_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d, div_q, div_d;
  logic busy_q, busy_d, sck_q, sck_d, so_q, so_d, smp_q, smp_d;
  logic irq_q, irq_d, push_q, push_d, phase_q, phase_d;
  logic sck_oe_n_q, sck_oe_n_d, so_oe_n_q, so_oe_n_d;
  logic master, alt, rise_ev, fall_ev, sample_ev, out_ev;

  // pins: bit4 config = data out, bit5 config = clock direction
  assign master = port_g_config_in[1];
  assign alt = phase_q;

  // edge events: internal clock toggles in master, synchronised pin in slave
  always_comb begin
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    if (master) begin
      if (st_q != ST_IDLE && div_q == 4'h1) begin
        rise_ev = !sck_q;
        fall_ev = sck_q;
      end
    end else begin
      rise_ev = ck_rise;
      fall_ev = ck_fall;
    end
    sample_ev = alt ? fall_ev : rise_ev;
    out_ev = alt ? rise_ev : fall_ev;
  end

  // shift engine next state
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    div_d = div_q;
    busy_d = busy_q;
    sck_d = sck_q;
    so_d = so_q;
    smp_d = smp_q;
    irq_d = 1'b0;
    push_d = 1'b0;
    phase_d = port_g_config_in[2];
    sck_oe_n_d = !(serial_port_select_in && master);
    so_oe_n_d = !(serial_port_select_in && port_g_config_in[0]);
    if (load_in && !sck_q) begin
      sh_d = load_data_in; // load honoured only with clock low
    end
    if (busy_set_in && serial_port_select_in) begin
      busy_d = 1'b1;
    end
    case (st_q)
      ST_IDLE: begin
        sck_d = 1'b0;
        so_d = sh_d[7];
        if (busy_d) begin
          st_d = ST_LOW;
          cnt_d = 4'h0;
          div_d = half_period(rate_select_high_in, rate_select_low_in);
        end
      end
      ST_LOW, ST_HIGH: begin
        if (busy_clear_in || !serial_port_select_in) begin
          busy_d = 1'b0; // early stop, partial byte kept
          st_d = ST_IDLE;
          sck_d = 1'b0;
        end else begin
          if (master) begin
            div_d = (div_q == 4'h1) ?
              half_period(rate_select_high_in, rate_select_low_in) :
              div_q - 4'h1;
            if (rise_ev) begin
              sck_d = 1'b1; // only master drives the clock
            end
            if (fall_ev) begin
              sck_d = 1'b0;
            end
          end
          if (sample_ev) begin
            smp_d = master ? si_lvl : si_lvl;
          end
          if (out_ev && cnt_q != 4'h0 || (out_ev && alt && cnt_q == 4'h0 &&
              1'b0)) begin
            so_d = sh_q[7];
          end
          if (fall_ev) begin
            // register advances on falling edge, msb first
            sh_d = {sh_q[6:0], alt ? si_lvl : smp_q};
            cnt_d = cnt_q + 4'h1;
            so_d = alt ? so_q : sh_q[6];
            if (cnt_q + 4'h1 == BIT_COUNT) begin
              busy_d = 1'b0;
              st_d = ST_IDLE;
              push_d = 1'b1;
              irq_d = int_enable_in;
            end
          end
          if (rise_ev && alt) begin
            so_d = sh_q[7]; // present on rising edge
          end
          st_d = (busy_d == 1'b0) ? ST_IDLE : (sck_d ? ST_HIGH : ST_LOW);
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= ST_IDLE;
      sh_q <= SHREG_RESET;
      cnt_q <= 4'h0;
      div_q <= 4'h0;
      busy_q <= 1'b0;
      sck_q <= 1'b0;
      so_q <= 1'b0;
      smp_q <= 1'b0;
      irq_q <= 1'b0;
      push_q <= 1'b0;
      phase_q <= PHASE_RESET;
      sck_oe_n_q <= 1'b1;
      so_oe_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      busy_q <= busy_d;
      sck_q <= sck_d;
      so_q <= so_d;
      smp_q <= smp_d;
      irq_q <= irq_d;
      push_q <= push_d;
      phase_q <= phase_d;
      sck_oe_n_q <= sck_oe_n_d;
      so_oe_n_q <= so_oe_n_d;
    end
  end

  // completed bytes go to the FIFO; a full FIFO drops the byte
  assign rx_if.valid = push_q;
  assign rx_if.data = sh_q;

  assign busy_out = busy_q;
  assign shift_data_out = sh_q;
  assign done_irq_out = irq_q;
  assign shift_clock_out = sck_q;
  assign shift_clock_oe_n_out = sck_oe_n_q;
  assign serial_out = so_q;
  assign serial_oe_n_out = so_oe_n_q;
endmodule : sync_serial_shift_port
`default_nettype wire

//--- shift_port_pkg.sv
// shift_port_pkg: constants and types shared by the serial shift port files.
// assumes a 100 MHz core clock standing in for the instruction cycle clock.
`default_nettype none
package shift_port_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] BIT_COUNT = 4'h8;
  // shift clock periods in core cycles, half periods derived
  localparam logic [3:0] RATE_PERIOD_00 = 4'h2;
  localparam logic [3:0] RATE_PERIOD_01 = 4'h4;
  localparam logic [3:0] RATE_PERIOD_1X = 4'h8;
  localparam logic [7:0] SHREG_RESET = 8'h00;
  localparam logic PHASE_RESET = 1'b0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b11
  } shift_state_t;
endpackage : shift_port_pkg
`default_nettype wire

//--- byte_stream_if.sv
// byte_stream_if: valid/ready byte stream between internal modules.
// assumes producer and consumer share the core clock.
`default_nettype none
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

//--- byte_fifo.sv
// byte_fifo: synchronous FIFO with valid/ready on both sides.
// assumes one clock; full and empty are exact.
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // occupancy bookkeeping
  always_comb begin
    push = in_valid_in && in_ready_out; // a full FIFO refuses the word
    pop = out_valid_out && out_ready_in;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end

  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem[rd_q];
endmodule : byte_fifo
`default_nettype wire

//--- link_sampler.sv
// link_sampler: three-stage synchroniser for the link inputs with edges.
// assumes inputs are asynchronous to clk_in.
`default_nettype none
module link_sampler (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // raw pins
  input wire logic clk_pin_in,
  input wire logic data_pin_in,
  // filtered levels and edges
  output logic clk_level_out,
  output logic clk_rise_out,
  output logic clk_fall_out,
  output logic data_level_out
);
  logic [2:0] ck_q, dt_q;
  logic ck_lvl_q, ck_lvl_d, dt_lvl_q, dt_lvl_d;

  // a change counts only once stages two and three agree
  always_comb begin
    ck_lvl_d = (ck_q[1] == ck_q[2]) ? ck_q[2] : ck_lvl_q;
    dt_lvl_d = (dt_q[1] == dt_q[2]) ? dt_q[2] : dt_lvl_q;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ck_q <= 3'h0;
      dt_q <= 3'h0;
      ck_lvl_q <= 1'b0;
      dt_lvl_q <= 1'b0;
    end else begin
      ck_q <= {ck_q[1:0], clk_pin_in};
      dt_q <= {dt_q[1:0], data_pin_in};
      ck_lvl_q <= ck_lvl_d;
      dt_lvl_q <= dt_lvl_d;
    end
  end

  assign clk_level_out = ck_lvl_q;
  assign clk_rise_out = ck_lvl_d && !ck_lvl_q;
  assign clk_fall_out = !ck_lvl_d && ck_lvl_q;
  // data level leaves one stage early so that, as master, a bit that the
  // partner turns on our own edge is seen before the next edge of the
  // slowest shift clock; it still needs stages two and three to agree
  assign data_level_out = dt_lvl_d;
endmodule : link_sampler
`default_nettype wire

//--- shift_port_props.sv
// shift_port_props: checker on the serial shift port top-level ports.
// assumes mode and rate inputs hold steady while a byte is in flight.
`default_nettype none
module shift_port_props (
  // clock, reset and controls
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic serial_port_select_in,
  input wire logic rate_select_low_in,
  input wire logic rate_select_high_in,
  input wire logic int_enable_in,
  input wire logic [2:0] port_g_config_in,
  input wire logic busy_set_in,
  input wire logic busy_clear_in,
  // watched outputs
  input wire logic busy_out,
  input wire logic done_irq_out,
  input wire logic shift_clock_out,
  input wire logic shift_clock_oe_n_out,
  input wire logic serial_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_q;
  logic [3:0] rise_cnt_q;
  wire logic mst = port_g_config_in[1];
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  // rises of the shift clock within one busy period
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sck_q <= 1'b0;
      rise_cnt_q <= 4'h0;
    end else begin
      sck_q <= shift_clock_out;
      if (!busy_out) rise_cnt_q <= 4'h0;
      else if (shift_clock_out && !sck_q) rise_cnt_q <= rise_cnt_q + 4'h1;
    end
  end
  sequence s_r2;
    !shift_clock_out ##1 shift_clock_out ##1 !shift_clock_out;
  endsequence
  sequence s_r8;
    !shift_clock_out [*4] ##1 shift_clock_out [*4] ##1 !shift_clock_out;
  endsequence
  // a byte ended by itself, not by software
  sequence s_end;
    $fell(busy_out) && !$past(busy_clear_in);
  endsequence
  property p_idle;
    !busy_out ##1 !busy_out |-> !shift_clock_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("shift clock not resting low");
  property p_sck_oe;
    $past(nrst_in) |->
      shift_clock_oe_n_out == !$past(serial_port_select_in && mst);
  endproperty
  a_sck_oe: assert property (p_sck_oe)
    else $error("shift clock enable wrong");
  property p_so_oe;
    $past(nrst_in) |->
      serial_oe_n_out == !$past(serial_port_select_in && port_g_config_in[0]);
  endproperty
  a_so_oe: assert property (p_so_oe)
    else $error("serial out enable wrong");
  property p_start;
    serial_port_select_in && busy_set_in && !busy_clear_in && !busy_out
      |=> busy_out;
  endproperty
  a_start: assert property (p_start)
    else $error("busy not set");
  property p_abort;
    busy_out && busy_clear_in && !busy_set_in |=> !busy_out;
  endproperty
  a_abort: assert property (p_abort)
    else $error("busy not cleared");
  property p_r2;
    $rose(busy_out) && mst && !rate_select_high_in && !rate_select_low_in
      |-> s_r2;
  endproperty
  a_r2: assert property (p_r2)
    else $error("fast rate period wrong");
  property p_r8;
    $rose(busy_out) && mst && rate_select_high_in |-> s_r8;
  endproperty
  a_r8: assert property (p_r8)
    else $error("slow rate period wrong");
  property p_eight;
    s_end ##0 mst |-> rise_cnt_q == 4'h8;
  endproperty
  a_eight: assert property (p_eight)
    else $error("byte not eight clocks");
  property p_irq;
    s_end ##0 int_enable_in |-> ##[0:1] done_irq_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("no irq after byte");
  property p_pulse;
    done_irq_out |=> !done_irq_out;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("irq longer than one cycle");
  property p_no_irq;
    !int_enable_in && !$past(int_enable_in) |-> !done_irq_out;
  endproperty
  a_no_irq: assert property (p_no_irq)
    else $error("irq while disabled");
endmodule : shift_port_props
bind sync_serial_shift_port shift_port_props i_shift_port_props (
  .clk_in, .nrst_in, .serial_port_select_in, .rate_select_low_in,
  .rate_select_high_in, .int_enable_in, .port_g_config_in, .busy_set_in,
  .busy_clear_in, .busy_out, .done_irq_out, .shift_clock_out,
  .shift_clock_oe_n_out, .serial_oe_n_out
);
`default_nettype wire

//--- link_peer.sv
// link_peer: far end of the shift link, a byte-wide shift partner.
// assumes the bench primes it between frames while the clock rests low.
`default_nettype none
module link_peer (
  // link lines
  input wire logic sck_dut_in,
  input wire logic so_in,
  output logic sck_out,
  output logic si_out,
  // mode and result
  input wire logic master_in,
  input wire logic alt_in,
  output logic [7:0] got_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  wire logic line = master_in ? sck_dut_in : sck_out;
  initial begin
    sck_out = 1'b0;
    si_out = 1'b0;
    got_out = 8'h00;
  end
  // spent bits are refilled inverted so a stale level never looks valid
  task prime(input logic [7:0] b, input logic alt);
    sh = alt ? b : {b[6:0], ~b[7]};
    si_out = alt ? ~b[7] : b[7];
  endtask : prime
  // eight 160 ns periods, each 80 ns high, resting low; only a master frames
  task frame;
    #7;
    repeat (8) begin
      #80 sck_out = 1'b1;
      #80 sck_out = 1'b0;
    end
  endtask : frame
  // msb first; capture on one edge, change on the other
  always @(posedge line) begin
    if (alt_in) begin
      si_out <= sh[7];
      sh <= {sh[6:0], ~sh[7]};
    end else got_out <= {got_out[6:0], so_in};
  end
  always @(negedge line) begin
    if (!alt_in) begin
      si_out <= sh[7];
      sh <= {sh[6:0], ~sh[7]};
    end else got_out <= {got_out[6:0], so_in};
  end
endmodule : link_peer
`default_nettype wire

//--- tb_top.sv
// tb_top: self-checking bench for the serial shift port with a link peer.
// assumes the checker binds itself to the port from its own file.
`default_nettype none
module tb_top;
  import shift_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, nrst_in, sel, rlo, rhi, ien, bset, bclr, load, rdy;
  logic busy, rval, irq, si, sck_i, sck_o, sck_oe_n, so, so_oe_n;
  logic [2:0] cfg;
  logic [7:0] ldat, rdat, sdat, got;
  int fails, compares, cycles, irqs, exp_irq;
  logic [7:0] exp_q[$];
  sync_serial_shift_port i_sync_serial_shift_port (
    .clk_in(clk_in), .nrst_in(nrst_in), .serial_port_select_in(sel),
    .rate_select_low_in(rlo), .rate_select_high_in(rhi),
    .int_enable_in(ien), .port_g_config_in(cfg), .busy_set_in(bset),
    .busy_clear_in(bclr), .busy_out(busy), .load_in(load),
    .load_data_in(ldat), .shift_data_out(sdat), .rx_valid_out(rval),
    .rx_data_out(rdat), .rx_ready_in(rdy), .done_irq_out(irq),
    .serial_in(si), .shift_clock_in(sck_i), .shift_clock_out(sck_o),
    .shift_clock_oe_n_out(sck_oe_n), .serial_out(so),
    .serial_oe_n_out(so_oe_n));
  // a released data line reads inverted, not as its last level
  link_peer i_link_peer (.sck_dut_in(sck_o), .so_in(so_oe_n ? ~so : so),
    .sck_out(sck_i), .si_out(si), .master_in(cfg[1]), .alt_in(cfg[2]),
    .got_out(got));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // irq pulses counted here; the ceiling cuts a hang short
  always @(negedge clk_in) begin
    cycles++;
    if (irq === 1'b1) irqs++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task step;
    @(posedge clk_in);
    #1;
  endtask : step
  task chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk8
  task end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // one byte; cut above zero clears busy early after that many cycles
  task xfer(input logic m, input logic [1:0] r, input logic alt,
            input logic [7:0] d, input logic [7:0] pd, input int cut);
    int w;
    cfg = {alt, m, 1'b1};
    rhi = r[1];
    rlo = r[0];
    i_link_peer.prime(pd, alt);
    ldat = d;
    load = 1'b1;
    step();
    load = 1'b0;
    bset = 1'b1;
    step();
    bset = 1'b0;
    if (!m) i_link_peer.frame();
    for (w = 0; w < 600 && busy !== 1'b0; w++) begin
      bclr = (w == cut && cut > 0);
      step();
    end
    bclr = 1'b0;
    repeat (2) step();
    chk8("busy_done", 8'h00, {7'h00, busy});
    if (cut == 0) begin
      if (ien) exp_irq++;
      chk8("link_rx", d, got);
      if (r[1] || !m) chk8("shift_reg", pd, sdat);
      if ((r[1] || !m) && exp_q.size() < 8) exp_q.push_back(pd);
    end else chk8("aborted_rx", 8'h00, {7'h00, rval});
    chk8("irq_count", 8'(exp_irq), 8'(irqs));
  endtask : xfer
  task drain(input logic chk);
    logic [7:0] v;
    rdy = 1'b1;
    for (int n = 0; n < 9 && rval === 1'b1; n++) begin
      v = rdat;
      step();
      if (chk && exp_q.size() > 0) chk8("rx_data", exp_q.pop_front(), v);
    end
    rdy = 1'b0;
  endtask : drain
  initial begin
    {nrst_in, sel, rlo, rhi, ien, bset, bclr, load, rdy} = 9'h000;
    cfg = 3'h0;
    ldat = 8'h00;
    void'($urandom(85));
    repeat (2) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    chk8("reset_out", 8'h03, {2'h0, busy, sck_o, irq, rval, sck_oe_n, so_oe_n});
    cfg = 3'h3;
    bset = 1'b1;
    step();
    bset = 1'b0;
    step();
    chk8("unselected", 8'h03, {5'h00, busy, sck_oe_n, so_oe_n});
    sel = 1'b1;
    ien = 1'b1;
    // fast rates, both phases; received bytes not judged here
    for (int k = 0; k < 4; k++) xfer(1'b1, {1'b0, k[0]}, k[1], 8'($urandom), 8'($urandom), 0);
    drain(1'b0);
    for (int k = 0; k < 6; k++) xfer(1'b1, {1'b1, 1'($urandom)}, 1'($urandom), 8'($urandom), 8'($urandom), 0);
    xfer(1'b0, 2'h0, 1'b0, 8'h80, 8'h01, 0);
    xfer(1'b0, 2'h0, 1'b1, 8'hA5, 8'h5A, 0);
    ien = 1'b0;
    xfer(1'b1, 2'h2, 1'b0, 8'hFF, 8'h00, 0);
    drain(1'b1);
    chk8("fifo_left", 8'h00, {rval, 7'(exp_q.size())});
    ien = 1'b1;
    xfer(1'b1, 2'h3, 1'b0, 8'h3C, 8'hC3, 20);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
